/* File: rtl/fpm_consts.svh */
`ifndef FPM_CONSTS_SVH
`define FPM_CONSTS_SVH
// Notes on behaviour
// - Controller data forwarded to 128 virtual inputs
// - Base unit virtual outputs presented as controller input
// - Each 32-bit group selectable, sets data width
// - Status bits 0-3 mirror error/notice lamps
// - Bit 5 shows data exchange with base unit
// - Table/segment request answered with fifteen bytes
// - Configure and start alone after reset
// - IP address by DHCP or unit name

// ****************************************************
// Process data layout
// ****************************************************
`define FPM_GRP_W        32
`define FPM_NGRP         4
`define FPM_GRP_BYTES    4
`define FPM_REQ_BYTES    2
`define FPM_RSP_BYTES    15

// ****************************************************
// Lamp status byte fields
// ****************************************************
`define FPM_LS_OUT_ERR   0
`define FPM_LS_IN_ERR    1
`define FPM_LS_GEN_ERR   2
`define FPM_LS_MAINT     3
`define FPM_LS_SAFE_RUN  4
`define FPM_LS_XCHG      5
`define FPM_LS_STD_RUN   6
`define FPM_LS_RESV      7
`define FPM_LS_RESET     8'h00

// ****************************************************
// Timing
// ****************************************************
`define FPM_CLK_NS       20
`define FPM_CFG_CYCLES   16
`define FPM_XCHG_HOLD_NS 10000000
`define FPM_XCHG_CYC     (`FPM_XCHG_HOLD_NS / `FPM_CLK_NS)
`endif

/* File: rtl/fpm_pkg.sv */
package fpm_pkg;
   // Start-up sequencer
   typedef enum logic [1:0] {
      fpm_st_cfg    = 2'b00,
      fpm_st_ipwait = 2'b01,
      fpm_st_run    = 2'b10
   } fpm_state_t;

   // One segment of the payload table, fifteen bytes
   typedef logic [119:0] fpm_seg_t;
   // Table or segment number as carried in a poll
   typedef logic [7:0]   fpm_num_t;
endpackage

/* File: rtl/fpm_table.sv */
`timescale 1ns/1ns
`include "fpm_consts.svh"
module fpm_table #(
   parameter int NTAB = 4,
   parameter int NSEG = 8
) (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic nrst_i,
   // Table access
   fpm_tbl_if.responder tbl
);
   import fpm_pkg::*;

   localparam int DEPTH = NTAB * NSEG;

   initial begin
      if (NTAB < 1 || NTAB > 256 || NSEG < 1 || NSEG > 256)
         $error("fpm_table: table or segment count out of range");
   end

   fpm_seg_t mem_q [DEPTH];
   fpm_seg_t rd_data_q;
   logic     rd_valid_q;

   // Flat index; out-of-range numbers flagged
   function automatic logic in_range(input fpm_num_t t, input fpm_num_t s);
      return (32'(t) < NTAB) && (32'(s) < NSEG);
   endfunction

   function automatic int idx(input fpm_num_t t, input fpm_num_t s);
      return 32'(t) * NSEG + 32'(s);
   endfunction

   // Base unit fills the table; no reset, contents are data only
   always_ff @(posedge ref_clk_i) begin
      if (tbl.wr_en && in_range(tbl.wr_table, tbl.wr_seg)) begin
         mem_q[idx(tbl.wr_table, tbl.wr_seg)] <= tbl.wr_data;
      end
   end

   // One-cycle read; unknown segments answer with zeros
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         rd_valid_q <= 1'b0;
         rd_data_q  <= '0;
      end else begin
         rd_valid_q <= tbl.rd_req;
         if (tbl.rd_req) begin
            rd_data_q <= in_range(tbl.rd_table, tbl.rd_seg) ?
                         mem_q[idx(tbl.rd_table, tbl.rd_seg)] : '0;
         end
      end
   end

   assign tbl.rd_valid = rd_valid_q;
   assign tbl.rd_data  = rd_data_q;
endmodule

/* File: rtl/fpm_tbl_if.sv */
`timescale 1ns/1ns
interface fpm_tbl_if;
   import fpm_pkg::*;
   logic     rd_req;
   fpm_num_t rd_table;
   fpm_num_t rd_seg;
   logic     rd_valid;
   fpm_seg_t rd_data;
   logic     wr_en;
   fpm_num_t wr_table;
   fpm_num_t wr_seg;
   fpm_seg_t wr_data;

   modport requester (output rd_req, rd_table, rd_seg, wr_en, wr_table,
                      wr_seg, wr_data, input rd_valid, rd_data);
   modport responder (input rd_req, rd_table, rd_seg, wr_en, wr_table,
                      wr_seg, wr_data, output rd_valid, rd_data);
endinterface

/* File: rtl/fpm_top.sv */
`timescale 1ns/1ns
`include "fpm_consts.svh"
module fpm_top #(
   parameter int NTAB     = 4,
   parameter int NSEG     = 8,
   parameter int XCHG_CYC = `FPM_XCHG_CYC
) (
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              nrst_i,
   // Start-up and addressing
   input  wire logic              ip_use_dhcp_i,
   input  wire logic              ip_valid_i,
   output logic                   ip_mode_dhcp_o,
   output logic                   running_o,
   // Controller process data
   input  wire logic [3:0]        grp_sel_i,
   input  wire logic              ctl_out_valid_i,
   input  wire logic [127:0]      ctl_out_data_i,
   output logic [127:0]           ctl_in_data_o,
   output logic [4:0]             ctl_in_bytes_o,
   // Base unit process data
   input  wire logic              bu_vout_valid_i,
   input  wire logic [127:0]      bu_vout_i,
   output logic                   bu_vin_valid_o,
   output logic [127:0]           bu_vin_o,
   // Base unit lamps and reset, asynchronous pins
   input  wire logic              output_error_lamp_i,
   input  wire logic              input_error_lamp_i,
   input  wire logic              general_error_lamp_i,
   input  wire logic              maint_notice_lamp_i,
   input  wire logic              safety_program_running_lamp_i,
   input  wire logic              standard_program_running_lamp_i,
   input  wire logic              has_std_program_i,
   input  wire logic              bu_reset_i,
   output logic [7:0]             base_unit_lamp_status_o,
   // Payload table poll
   input  wire logic              req_valid_i,
   input  wire fpm_pkg::fpm_num_t req_table_i,
   input  wire fpm_pkg::fpm_num_t req_seg_i,
   output logic                   rsp_valid_o,
   output fpm_pkg::fpm_seg_t      rsp_data_o,
   // Payload table fill by base unit
   input  wire logic              tbl_wr_i,
   input  wire fpm_pkg::fpm_num_t tbl_wr_table_i,
   input  wire fpm_pkg::fpm_num_t tbl_wr_seg_i,
   input  wire fpm_pkg::fpm_seg_t tbl_wr_data_i
);
   import fpm_pkg::*;

   localparam int A_CFG_MAX = `FPM_CFG_CYCLES + 1;

   initial begin
      if (XCHG_CYC < 1 || XCHG_CYC > 16777215)
         $error("fpm_top: XCHG_CYC out of range");
   end

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   logic [7:0] pin_raw;
   logic [7:0] s1_q, s2_q, s3_q, pin_q;

   assign pin_raw = {bu_reset_i, has_std_program_i,
                     standard_program_running_lamp_i,
                     safety_program_running_lamp_i, maint_notice_lamp_i,
                     general_error_lamp_i, input_error_lamp_i,
                     output_error_lamp_i};

   // Three stages; value accepted only once stages 2 and 3 agree
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         s1_q  <= 8'h00;
         s2_q  <= 8'h00;
         s3_q  <= 8'h00;
         pin_q <= 8'h00;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int b = 0; b < 8; b++) begin
            if (s2_q[b] == s3_q[b])
               pin_q[b] <= s3_q[b];
         end
      end
   end

   // ****************************************************
   // Start-up sequencer
   // ****************************************************
   fpm_state_t state_q;
   logic [4:0] cfg_cnt_q;
   logic       run;

   assign run       = (state_q == fpm_st_run);
   assign running_o = run;

   // Self-start after reset or base unit reset, no command needed
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         state_q   <= fpm_st_cfg;
         cfg_cnt_q <= 5'h00;
      end else if (pin_q[7]) begin
         state_q   <= fpm_st_cfg;
         cfg_cnt_q <= 5'h00;
      end else begin
         case (state_q)
            fpm_st_cfg: begin
               cfg_cnt_q <= cfg_cnt_q + 5'h01;
               if (cfg_cnt_q == 5'(`FPM_CFG_CYCLES - 1))
                  state_q <= fpm_st_ipwait;
            end
            fpm_st_ipwait: begin
               // No exchange until an address is held
               if (ip_valid_i)
                  state_q <= fpm_st_run;
            end
            fpm_st_run: begin
               if (!ip_valid_i)
                  state_q <= fpm_st_ipwait;
            end
            default: state_q <= fpm_st_cfg;
         endcase
      end
   end

   // Address method strap, caught while configuring
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i)
         ip_mode_dhcp_o <= 1'b0;
      else if (state_q == fpm_st_cfg)
         ip_mode_dhcp_o <= ip_use_dhcp_i;
   end

   // ****************************************************
   // Process data
   // ****************************************************
   logic [3:0] sel_q;

   // Group mask, shared by both directions
   function automatic logic [127:0] grp_mask(input logic [3:0] sel);
      logic [127:0] m;
      m = '0;
      for (int g = 0; g < `FPM_NGRP; g++)
         m[g*`FPM_GRP_W +: `FPM_GRP_W] = {`FPM_GRP_W{sel[g]}};
      return m;
   endfunction

   // Selection taken once per cycle so both directions agree
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i)
         sel_q <= 4'h0;
      else
         sel_q <= grp_sel_i;
   end

   // Width in bytes follows the selected groups
   assign ctl_in_bytes_o = 5'(`FPM_GRP_BYTES * $countones(sel_q));

   // Controller output data to base unit virtual inputs
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         bu_vin_o       <= '0;
         bu_vin_valid_o <= 1'b0;
      end else begin
         bu_vin_valid_o <= run && ctl_out_valid_i;
         if (run && ctl_out_valid_i)
            bu_vin_o <= ctl_out_data_i & grp_mask(sel_q);
      end
   end

   // Base unit virtual outputs to controller input data
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i)
         ctl_in_data_o <= '0;
      else if (run && bu_vout_valid_i)
         ctl_in_data_o <= bu_vout_i & grp_mask(sel_q);
   end

   // ****************************************************
   // Lamp status byte
   // ****************************************************
   logic [23:0] xchg_cnt_q;
   logic        xchg;

   assign xchg = run && (ctl_out_valid_i || bu_vout_valid_i);

   // Activity held so a slow poll still sees an exchange
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i)
         xchg_cnt_q <= 24'h000000;
      else if (xchg)
         xchg_cnt_q <= 24'(XCHG_CYC);
      else if (xchg_cnt_q != 24'h000000)
         xchg_cnt_q <= xchg_cnt_q - 24'h000001;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         base_unit_lamp_status_o <= `FPM_LS_RESET;
      end else begin
         base_unit_lamp_status_o[`FPM_LS_OUT_ERR] <= pin_q[0];
         base_unit_lamp_status_o[`FPM_LS_IN_ERR]  <= pin_q[1];
         base_unit_lamp_status_o[`FPM_LS_GEN_ERR] <= pin_q[2];
         base_unit_lamp_status_o[`FPM_LS_MAINT]   <= pin_q[3];
         base_unit_lamp_status_o[`FPM_LS_SAFE_RUN] <= pin_q[4];
         // Base units without standard program never show it
         base_unit_lamp_status_o[`FPM_LS_STD_RUN] <=
            pin_q[5] & pin_q[6];
         base_unit_lamp_status_o[`FPM_LS_XCHG] <=
            xchg || (xchg_cnt_q != 24'h000000);
         base_unit_lamp_status_o[`FPM_LS_RESV] <= 1'b0;
      end
   end

   // ****************************************************
   // Payload table poll
   // ****************************************************
   fpm_tbl_if tbl ();

   assign tbl.rd_req   = run && req_valid_i;
   assign tbl.rd_table = req_table_i;
   assign tbl.rd_seg   = req_seg_i;
   assign tbl.wr_en    = tbl_wr_i;
   assign tbl.wr_table = tbl_wr_table_i;
   assign tbl.wr_seg   = tbl_wr_seg_i;
   assign tbl.wr_data  = tbl_wr_data_i;
   assign rsp_valid_o  = tbl.rd_valid;
   assign rsp_data_o   = tbl.rd_data;

   fpm_table #(
      .NTAB (NTAB),
      .NSEG (NSEG)
   ) u_table (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .tbl       (tbl)
   );

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   a_vin_forward: assert property (
      run && ctl_out_valid_i |=> bu_vin_valid_o &&
      bu_vin_o == ($past(ctl_out_data_i) & grp_mask($past(sel_q))))
      else $error("virtual inputs not forwarded");
   a_vout_present: assert property (
      run && bu_vout_valid_i |=>
      ctl_in_data_o == ($past(bu_vout_i) & grp_mask($past(sel_q))))
      else $error("virtual outputs not presented");
   a_width_bytes: assert property (
      nrst_i |=> ctl_in_bytes_o ==
      5'(`FPM_GRP_BYTES * $countones($past(grp_sel_i))))
      else $error("data width wrong");
   a_err_lamps: assert property (
      $stable(pin_q[3:0]) [*2] |-> base_unit_lamp_status_o[3:0] == pin_q[3:0])
      else $error("error lamp bits wrong");
   a_run_lamps: assert property (
      !pin_q[6] |=> !base_unit_lamp_status_o[`FPM_LS_STD_RUN])
      else $error("standard run shown without program");
   a_xchg_bit: assert property (
      xchg |=> base_unit_lamp_status_o[`FPM_LS_XCHG] [*2])
      else $error("exchange bit not set");
   a_poll_reply: assert property (
      run && req_valid_i |=> rsp_valid_o ##1 !$past(tbl.rd_req) ||
      rsp_valid_o)
      else $error("poll not answered");
   a_self_start: assert property (
      state_q == fpm_st_cfg && !pin_q[7] && !s3_q[7] && !s2_q[7]
      && !s1_q[7] && !bu_reset_i |-> ##[1:A_CFG_MAX]
      state_q != fpm_st_cfg)
      else $error("no self start");
   a_ip_gate: assert property (
      state_q == fpm_st_ipwait && !ip_valid_i && !pin_q[7] |=>
      state_q == fpm_st_ipwait)
      else $error("ran without address");
   a_resv_zero: assert property (
      !base_unit_lamp_status_o[`FPM_LS_RESV])
      else $error("reserved bit set");
endmodule

/* File: test/fieldbus_process_image_mapper_bench.sv */
`timescale 1ns/1ns
// ************************************************
// Bench top
// ************************************************
module fieldbus_process_image_mapper_bench;
   import fpm_pkg::*;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic dhcp = 1'b1, ipv = 1'b1, bu_v = 1'b0, bu_rst = 1'b0;
   logic has_std = 1'b1, twr = 1'b0;
   logic [127:0] bu_d = '0;
   logic [5:0] lamp = '0;
   fpm_num_t twt = '0, tws = '0;
   fpm_seg_t twd = '0;
   logic [3:0] sel;
   logic ov, rv, run, mode, vinv, rspv;
   logic [127:0] od, cin, vin;
   fpm_num_t rt, rs;
   logic [4:0] nby;
   logic [7:0] st;
   fpm_seg_t rsp;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   fpm_ctl_model fpm_ctl_model_inst (.ref_clk_i(ref_clk_i),
      .grp_sel_o(sel), .out_valid_o(ov), .out_data_o(od),
      .req_valid_o(rv), .req_table_o(rt), .req_seg_o(rs));
   fpm_top #(.XCHG_CYC(8)) fpm_top_inst (.ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i), .ip_use_dhcp_i(dhcp), .ip_valid_i(ipv),
      .ip_mode_dhcp_o(mode), .running_o(run), .grp_sel_i(sel),
      .ctl_out_valid_i(ov), .ctl_out_data_i(od), .ctl_in_data_o(cin),
      .ctl_in_bytes_o(nby), .bu_vout_valid_i(bu_v), .bu_vout_i(bu_d),
      .bu_vin_valid_o(vinv), .bu_vin_o(vin),
      .output_error_lamp_i(lamp[0]), .input_error_lamp_i(lamp[1]),
      .general_error_lamp_i(lamp[2]), .maint_notice_lamp_i(lamp[3]),
      .safety_program_running_lamp_i(lamp[4]),
      .standard_program_running_lamp_i(lamp[5]),
      .has_std_program_i(has_std), .bu_reset_i(bu_rst),
      .base_unit_lamp_status_o(st), .req_valid_i(rv),
      .req_table_i(rt), .req_seg_i(rs), .rsp_valid_o(rspv),
      .rsp_data_o(rsp), .tbl_wr_i(twr), .tbl_wr_table_i(twt),
      .tbl_wr_seg_i(tws), .tbl_wr_data_i(twd));
   // Clock, 20 ns period
   initial begin
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   // Hang guard; the tests need well under this many cycles
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         close_out();
      end
   end
   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic close_out();
      if (fail_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [127:0] g, e, input string m);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   // Bounded wait for run state
   task automatic wait_run();
      for (int i = 0; i < 100 && run !== 1'b1; i++) tick(1);
   endtask
   function automatic logic [127:0] mask(input logic [3:0] s);
      for (int g = 0; g < 4; g++) mask[32*g +: 32] = {32{s[g]}};
   endfunction
   task automatic bu_send(input logic [127:0] d);
      tick(0);
      @(posedge ref_clk_i);
      #1 bu_v = 1'b1;
      bu_d = d;
      tick(1);
      bu_v = 1'b0;
      bu_d = ~d;
   endtask
   task automatic tbl_put(input fpm_num_t t, s, input fpm_seg_t d);
      @(posedge ref_clk_i);
      #1 twr = 1'b1;
      {twt, tws, twd} = {t, s, d};
      tick(1);
      twr = 1'b0;
   endtask
   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_start();
      tick(10);
      chk(run, 1'b0, "running during config");
      wait_run();
      chk(run, 1'b1, "no self start");
      chk(mode, 1'b1, "dhcp strap");
      dhcp = 1'b0;
      bu_rst = 1'b1;
      tick(6);
      bu_rst = 1'b0;
      tick(6);
      chk(run, 1'b0, "base unit reset ignored");
      wait_run();
      chk(run, 1'b1, "no restart");
      chk(mode, 1'b0, "name strap");
      // Address lost: back to waiting, process data refused
      ipv = 1'b0;
      tick(1);
      chk(run, 1'b0, "ran without address");
      fpm_ctl_model_inst.send(128'h1);
      chk(vinv, 1'b0, "strobe outside run");
      chk(vin, 128'h0, "data taken outside run");
      ipv = 1'b1;
      tick(1);
      chk(run, 1'b1, "no resume with address");
   endtask
   task automatic t_vin(input logic [3:0] s, input logic [4:0] n);
      logic [127:0] d;
      d = 128'hFEDCBA98_76543210_0F1E2D3C_A5A55A5A;
      fpm_ctl_model_inst.select(s);
      fpm_ctl_model_inst.send(d);
      chk(vinv, 1'b1, "vin strobe");
      chk(vin, d & mask(s), "vin data");
      chk(nby, n, "byte count");
      tick(1);
      chk(vinv, 1'b0, "vin strobe length");
   endtask
   task automatic t_vout(input logic [3:0] s);
      logic [127:0] d;
      d = 128'h13579BDF_2468ACE0_C3C3C3C3_00FF00FF;
      fpm_ctl_model_inst.select(s);
      bu_send(d);
      chk(cin, d & mask(s), "vout data");
      tick(2);
      chk(st[5], 1'b1, "exchange flag");
      tick(20);
      chk(st, 8'h00, "exchange flag stuck");
   endtask
   task automatic t_lamps();
      int bitpos[6] = '{0, 1, 2, 3, 4, 6};
      for (int i = 0; i < 6; i++) begin
         lamp = 6'(1 << i);
         tick(8);
         chk(st, 8'(1 << bitpos[i]), "lamp bit");
      end
      has_std = 1'b0;
      tick(8);
      chk(st, 8'h00, "std lamp without program");
      lamp = 6'h3F;
      tick(8);
      chk(st, 8'h1F, "all lamps");
      lamp = '0;
      has_std = 1'b1;
   endtask
   task automatic t_poll();
      fpm_seg_t a, b;
      a = 120'h0F0E0D0C_0B0A0908_07060504_030201;
      b = ~a;
      tbl_put(8'h01, 8'h07, a);
      tbl_put(8'h03, 8'h00, b);
      fpm_ctl_model_inst.poll(8'h01, 8'h07);
      chk(rspv, 1'b1, "poll strobe");
      chk(rsp, a, "segment bytes");
      fpm_ctl_model_inst.poll(8'h03, 8'h00);
      chk(rsp, b, "back to back poll");
      fpm_ctl_model_inst.poll(8'h04, 8'h00);
      chk(rsp, '0, "table out of range");
      // Non-zero answer first, so a stale zero cannot pass below
      fpm_ctl_model_inst.poll(8'h01, 8'h07);
      chk(rsp, a, "segment bytes again");
      fpm_ctl_model_inst.poll(8'h00, 8'h08);
      chk(rsp, '0, "segment out of range");
      tick(1);
      chk(rspv, 1'b0, "poll strobe length");
   endtask
   // Main sequence
   initial begin
      tick(12);
      nrst_i = 1'b1;
      t_start();
      t_vin(4'hF, 5'h10);
      t_vin(4'h5, 5'h08);
      t_vout(4'hA);
      t_vout(4'hF);
      t_lamps();
      t_poll();
      close_out();
   end
endmodule

/* File: test/fpm_ctl_model.sv */
`timescale 1ns/1ns
// ************************************************
// Controller side model
// ************************************************
module fpm_ctl_model (
   // Clock
   input  wire logic         ref_clk_i,
   // Process data and polls toward the device
   output logic [3:0]        grp_sel_o,
   output logic              out_valid_o,
   output logic [127:0]      out_data_o,
   output logic              req_valid_o,
   output fpm_pkg::fpm_num_t req_table_o,
   output fpm_pkg::fpm_num_t req_seg_o
);
   import fpm_pkg::*;
   // Idle levels at time zero
   initial begin
      grp_sel_o   = 4'hF;
      out_valid_o = 1'b0;
      out_data_o  = '0;
      req_valid_o = 1'b0;
      req_table_o = 8'h00;
      req_seg_o   = 8'h00;
   end
   // Group selection, a level
   task automatic select(input logic [3:0] sel);
      @(posedge ref_clk_i);
      #1 grp_sel_o = sel;
   endtask
   // One frame; released data inverted so stale values never match
   task automatic send(input logic [127:0] d);
      @(posedge ref_clk_i);
      #1 out_valid_o = 1'b1;
      out_data_o = d;
      @(posedge ref_clk_i);
      #1 out_valid_o = 1'b0;
      out_data_o = ~d;
   endtask
   // Two-byte poll: table number and segment number, driven in the same cycle
   task automatic poll(input fpm_num_t t, input fpm_num_t s);
      @(posedge ref_clk_i);
      #1 req_valid_o = 1'b1;
      req_table_o = t;
      req_seg_o = s;
      @(posedge ref_clk_i);
      #1 req_valid_o = 1'b0;
      req_table_o = ~t;
      req_seg_o = ~s;
   endtask
endmodule
